// ### core/bas_pkg.sv
package bas_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_NS = 10;
	// I2C device address and register indices
	localparam logic [3:0] DEV_ADDR_HI = 4'hE;
	localparam logic [7:0] IDX_MODE = 8'h00;
	localparam logic [7:0] IDX_CTRL = 8'h01;
	localparam logic [7:0] IDX_SOC_HI = 8'h02;
	localparam logic [7:0] IDX_SOC_LO = 8'h03;
	localparam logic [7:0] IDX_VOLT_HI = 8'h08;
	localparam logic [7:0] IDX_VOLT_LO = 8'h09;
	localparam logic [7:0] IDX_CHG_ALM = 8'h13;
	localparam logic [7:0] IDX_VOLT_ALM = 8'h14;
	// Field positions and values after reset
	localparam int MODE_ALM_EN_BIT = 3;
	localparam int CTRL_PIN_BIT = 0;
	localparam int CTRL_CHG_FLAG_BIT = 5;
	localparam int CTRL_VOLT_FLAG_BIT = 6;
	localparam logic [7:0] MODE_RST = 8'h09;
	localparam logic [7:0] CHG_ALM_RST = 8'h02;
	localparam logic [7:0] VOLT_ALM_RST = 8'hAA;
	// Synchroniser reset levels match the idle pin levels, so no false edge follows reset
	localparam logic [5:0] SYNC_RST = 6'h3C;
	// Timing
	localparam int SWAP_FILTER_MS = 1000;
	localparam int DEBOUNCE_MS = 10;
	localparam int SWAP_FILTER_CYC = CLK_HZ / 1000 * SWAP_FILTER_MS;
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int I2C_BIT_NS = 2500;
	localparam int I2C_QTR_CYC = (I2C_BIT_NS / CLK_NS + 3) / 4;
	// Host register byte offsets and command fields
	localparam logic [4:0] HR_CMD = 5'h00;
	localparam logic [4:0] HR_WDATA = 5'h04;
	localparam logic [4:0] HR_STATUS = 5'h08;
	localparam logic [4:0] HR_RDATA = 5'h0C;
	localparam logic [4:0] HR_ADDR_SEL = 5'h10;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CMD_TWO_BIT = 2;
endpackage

// ### core/bas_link_if.sv
`timescale 1ns/1ps
interface bas_link_if;
	logic scl;
	logic sda;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	// Open-drain data line with pull-up
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface

// ### core/bas_i2c_slave.sv
`timescale 1ns/1ps
module bas_i2c_slave
	import bas_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic restart,
	// Filtered bus levels
	input wire logic scl,
	input wire logic sda,
	input wire logic [6:0] dev_addr,
	output logic sda_low,
	// Register side
	output logic txn_start,
	output logic wr_stb,
	output logic [7:0] wr_data,
	output logic [7:0] reg_idx,
	input wire logic [7:0] rd_data
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_ADDR_ACK = 3'b010, S_IDX = 3'b011,
		S_IDX_ACK = 3'b100, S_WDATA = 3'b101, S_RDATA = 3'b110, S_RDATA_ACK = 3'b111
	} bas_sl_state_t;
	bas_sl_state_t state_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	logic mack_reg;
	logic data_ack_reg;
	logic start_cond;
	logic stop_cond;
	logic rise;
	logic fall;

	assign start_cond = scl && scl_prev_reg && sda_prev_reg && !sda;
	assign stop_cond = scl && scl_prev_reg && !sda_prev_reg && sda;
	assign rise = scl && !scl_prev_reg;
	assign fall = !scl && scl_prev_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl;
			sda_prev_reg <= sda;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			data_ack_reg <= 1'b0;
			sda_low <= 1'b0;
			txn_start <= 1'b0;
			wr_stb <= 1'b0;
			wr_data <= 8'h00;
			reg_idx <= 8'h00;
		end else if (restart) begin
			state_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			sda_low <= 1'b0;
			txn_start <= 1'b0;
			wr_stb <= 1'b0;
		end else begin
			txn_start <= 1'b0;
			wr_stb <= 1'b0;
			if (start_cond) begin
				state_reg <= S_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_low <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= S_IDLE;
				sda_low <= 1'b0;
			end else begin
				unique case (state_reg)
					S_IDLE: begin
					end
					S_ADDR, S_IDX, S_WDATA: begin
						if (rise && bit_cnt_reg != 4'h8) begin
							shift_reg <= {shift_reg[6:0], sda};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (fall && bit_cnt_reg == 4'h8) begin
							bit_cnt_reg <= 4'h0;
							if (state_reg == S_ADDR) begin
								if (shift_reg[7:1] == dev_addr) begin
									sda_low <= 1'b1;
									rw_reg <= shift_reg[0];
									txn_start <= 1'b1;
									state_reg <= S_ADDR_ACK;
								end else begin
									state_reg <= S_IDLE;
								end
							end else if (state_reg == S_IDX) begin
								reg_idx <= shift_reg;
								sda_low <= 1'b1;
								data_ack_reg <= 1'b0;
								state_reg <= S_IDX_ACK;
							end else begin
								wr_data <= shift_reg;
								wr_stb <= 1'b1;
								sda_low <= 1'b1;
								data_ack_reg <= 1'b1;
								state_reg <= S_IDX_ACK;
							end
						end
					end
					S_IDX_ACK: begin
						// Index moves on only after the strobed byte has been stored
						if (fall) begin
							sda_low <= 1'b0;
							state_reg <= S_WDATA;
							if (data_ack_reg) begin
								reg_idx <= reg_idx + 8'h01;
							end
						end
					end
					S_ADDR_ACK, S_RDATA_ACK: begin
						if (rise) begin
							mack_reg <= !sda;
						end
						if (fall) begin
							if (rw_reg && (state_reg == S_ADDR_ACK || mack_reg)) begin
								shift_reg <= rd_data;
								sda_low <= !rd_data[7];
								bit_cnt_reg <= 4'h1;
								reg_idx <= reg_idx + 8'h01;
								state_reg <= S_RDATA;
							end else if (!rw_reg) begin
								sda_low <= 1'b0;
								state_reg <= S_IDX;
							end else begin
								sda_low <= 1'b0;
								state_reg <= S_IDLE;
							end
						end
					end
					S_RDATA: begin
						if (fall) begin
							if (bit_cnt_reg == 4'h8) begin
								sda_low <= 1'b0;
								mack_reg <= 1'b0;
								state_reg <= S_RDATA_ACK;
							end else begin
								sda_low <= !shift_reg[6];
								shift_reg <= {shift_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
				endcase
			end
		end
	end
endmodule

// ### core/bas_device_end.sv
// Implementation choices: the I2C register port and the address map.
`timescale 1ns/1ps
module bas_device_end
	import bas_pkg::*;
#(
	parameter int SWAP_FILTER_CYCLES = SWAP_FILTER_CYC,
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register port link
	bas_link_if.device link,
	input wire logic [2:0] address_select,
	// Converter side
	output logic meas_start,
	input wire logic [15:0] voltage_value,
	input wire logic voltage_valid,
	input wire logic [15:0] charge_value,
	input wire logic charge_valid,
	// Pins
	input wire logic alarm_out_i,
	output logic alarm_out_o,
	output logic alarm_out_oe,
	input wire logic battery_detect_pin_i,
	output logic battery_detect_pin_o,
	output logic battery_detect_pin_oe,
	input wire logic system_reset_pin_i,
	output logic system_reset_pin_o,
	output logic system_reset_pin_oe,
	input wire logic supply_lockout
);
	localparam int SW_W = $clog2(SWAP_FILTER_CYCLES + 1);
	localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam int SY_SCL = 5;
	localparam int SY_SDA = 4;
	localparam int SY_ALM = 3;
	localparam int SY_RST = 2;
	localparam int SY_BATD = 1;
	localparam int SY_SUPPLY_LOCKOUT = 0;

	typedef enum logic [1:0] {
		ST_DEBOUNCE = 2'b00, ST_OCV = 2'b01, ST_RUN = 2'b10, ST_SWAP = 2'b11
	} bas_sup_state_t;

	logic [5:0] raw;
	logic [5:0] s1_reg;
	logic [5:0] s2_reg;
	logic [5:0] s3_reg;
	logic [5:0] filt_reg;
	bas_sup_state_t state_reg;
	logic [DB_W-1:0] dly_cnt_reg;
	logic [SW_W-1:0] swap_cnt_reg [2];
	logic [1:0] swap_long;
	logic restart_reg;
	logic hold_rst_reg;
	logic seen_v_reg;
	logic seen_c_reg;
	logic [7:0] mode_reg;
	logic pin_ctrl_reg;
	logic [7:0] chg_alm_reg;
	logic [7:0] volt_alm_reg;
	logic flag_v_reg;
	logic flag_c_reg;
	logic cond_v_reg;
	logic cond_c_reg;
	logic [15:0] volt_val_reg;
	logic [15:0] chg_val_reg;
	logic [15:0] volt_snap_reg;
	logic [15:0] chg_snap_reg;
	logic alm_en;
	logic volt_low;
	logic chg_low;
	logic set_v;
	logic set_c;
	logic wr_ctrl;
	logic sda_low;
	logic txn_start;
	logic wr_stb;
	logic [7:0] wr_data;
	logic [7:0] reg_idx;
	logic [7:0] rd_data;

	// Three-stage synchronisers; a level is taken once stages two and three agree
	assign raw = {link.scl, link.sda, alarm_out_i, system_reset_pin_i,
		battery_detect_pin_i, supply_lockout};
	for (genvar i = 0; i < 6; i++) begin : g_sync
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				s1_reg[i] <= SYNC_RST[i];
				s2_reg[i] <= SYNC_RST[i];
				s3_reg[i] <= SYNC_RST[i];
				filt_reg[i] <= SYNC_RST[i];
			end else begin
				s1_reg[i] <= raw[i];
				s2_reg[i] <= s1_reg[i];
				s3_reg[i] <= s2_reg[i];
				if (s2_reg[i] == s3_reg[i]) begin
					filt_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	bas_i2c_slave u_slave (
		.clock(clock),
		.arst_n(arst_n),
		.restart(restart_reg),
		.scl(filt_reg[SY_SCL]),
		.sda(filt_reg[SY_SDA]),
		.dev_addr({DEV_ADDR_HI, address_select}),
		.sda_low(sda_low),
		.txn_start(txn_start),
		.wr_stb(wr_stb),
		.wr_data(wr_data),
		.reg_idx(reg_idx),
		.rd_data(rd_data)
	);
	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = sda_low;

	// Filters run only while the supervisor is idle in normal operation
	assign swap_long[0] = swap_cnt_reg[0] > SW_W'(SWAP_FILTER_CYCLES);
	assign swap_long[1] = swap_cnt_reg[1] > SW_W'(SWAP_FILTER_CYCLES);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			swap_cnt_reg[0] <= '0;
			swap_cnt_reg[1] <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (state_reg != ST_RUN || !filt_reg[k]) begin
					swap_cnt_reg[k] <= '0;
				end else if (!swap_long[k]) begin
					swap_cnt_reg[k] <= swap_cnt_reg[k] + SW_W'(1);
				end
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_DEBOUNCE;
			dly_cnt_reg <= '0;
			restart_reg <= 1'b0;
			hold_rst_reg <= 1'b0;
			meas_start <= 1'b0;
			seen_v_reg <= 1'b0;
			seen_c_reg <= 1'b0;
		end else begin
			restart_reg <= 1'b0;
			meas_start <= 1'b0;
			unique case (state_reg)
				ST_DEBOUNCE: begin
					if (dly_cnt_reg == DB_W'(DEBOUNCE_CYCLES)) begin
						dly_cnt_reg <= '0;
						meas_start <= 1'b1;
						hold_rst_reg <= !filt_reg[SY_RST];
						seen_v_reg <= 1'b0;
						seen_c_reg <= 1'b0;
						state_reg <= ST_OCV;
					end else begin
						dly_cnt_reg <= dly_cnt_reg + DB_W'(1);
					end
				end
				ST_OCV: begin
					seen_v_reg <= seen_v_reg || voltage_valid;
					seen_c_reg <= seen_c_reg || charge_valid;
					if ((seen_v_reg || voltage_valid) && (seen_c_reg || charge_valid)) begin
						hold_rst_reg <= 1'b0;
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (swap_long != 2'b00) begin
						state_reg <= ST_SWAP;
					end
				end
				ST_SWAP: begin
					if (!filt_reg[SY_SUPPLY_LOCKOUT] && !filt_reg[SY_BATD]) begin
						restart_reg <= 1'b1;
						state_reg <= ST_DEBOUNCE;
					end
				end
			endcase
		end
	end

	assign battery_detect_pin_o = 1'b1;
	assign battery_detect_pin_oe = state_reg == ST_OCV;
	assign system_reset_pin_o = 1'b0;
	assign system_reset_pin_oe = state_reg == ST_OCV && hold_rst_reg;

	// Register file; a restart behaves like power-on
	assign wr_ctrl = wr_stb && reg_idx == IDX_CTRL;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= MODE_RST;
			pin_ctrl_reg <= 1'b1;
			chg_alm_reg <= CHG_ALM_RST;
			volt_alm_reg <= VOLT_ALM_RST;
		end else if (restart_reg) begin
			mode_reg <= MODE_RST;
			pin_ctrl_reg <= 1'b1;
			chg_alm_reg <= CHG_ALM_RST;
			volt_alm_reg <= VOLT_ALM_RST;
		end else if (wr_stb) begin
			if (reg_idx == IDX_MODE) begin
				mode_reg <= wr_data;
			end
			if (reg_idx == IDX_CTRL) begin
				pin_ctrl_reg <= wr_data[CTRL_PIN_BIT];
			end
			if (reg_idx == IDX_CHG_ALM) begin
				chg_alm_reg <= wr_data;
			end
			if (reg_idx == IDX_VOLT_ALM) begin
				volt_alm_reg <= wr_data;
			end
		end
	end

	// Thresholds scale to the result LSBs: 256 charge LSBs and 8 voltage LSBs per step
	assign alm_en = mode_reg[MODE_ALM_EN_BIT];
	assign volt_low = $signed(voltage_value) < $signed({5'h00, volt_alm_reg, 3'h0});
	assign chg_low = charge_value < {chg_alm_reg, 8'h00};
	// A condition raises its flag only on a fresh detection
	assign set_v = voltage_valid && alm_en && volt_low && !cond_v_reg;
	assign set_c = charge_valid && alm_en && chg_low && !cond_c_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cond_v_reg <= 1'b0;
			cond_c_reg <= 1'b0;
			flag_v_reg <= 1'b0;
			flag_c_reg <= 1'b0;
			volt_val_reg <= 16'h0000;
			chg_val_reg <= 16'h0000;
		end else if (restart_reg) begin
			cond_v_reg <= 1'b0;
			cond_c_reg <= 1'b0;
			flag_v_reg <= 1'b0;
			flag_c_reg <= 1'b0;
			volt_val_reg <= 16'h0000;
			chg_val_reg <= 16'h0000;
		end else begin
			if (voltage_valid) begin
				cond_v_reg <= alm_en && volt_low;
				volt_val_reg <= voltage_value;
			end
			if (charge_valid) begin
				cond_c_reg <= alm_en && chg_low;
				chg_val_reg <= charge_value;
			end
			// Set wins over a clear written in the same cycle
			flag_v_reg <= set_v || (flag_v_reg && !(wr_ctrl && !wr_data[CTRL_VOLT_FLAG_BIT]));
			flag_c_reg <= set_c || (flag_c_reg && !(wr_ctrl && !wr_data[CTRL_CHG_FLAG_BIT]));
		end
	end

	// Released only when both flags are clear and software allows it
	assign alarm_out_o = 1'b0;
	assign alarm_out_oe = !pin_ctrl_reg || flag_v_reg || flag_c_reg;

	// Snapshot at address match keeps both bytes of a value consistent
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			volt_snap_reg <= 16'h0000;
			chg_snap_reg <= 16'h0000;
		end else if (txn_start) begin
			volt_snap_reg <= volt_val_reg;
			chg_snap_reg <= chg_val_reg;
		end
	end

	always_comb begin
		rd_data = 8'h00;
		unique case (reg_idx)
			IDX_MODE: rd_data = mode_reg;
			IDX_CTRL: begin
				rd_data[CTRL_PIN_BIT] = filt_reg[SY_ALM];
				rd_data[CTRL_CHG_FLAG_BIT] = flag_c_reg;
				rd_data[CTRL_VOLT_FLAG_BIT] = flag_v_reg;
			end
			IDX_SOC_HI: rd_data = chg_snap_reg[15:8];
			IDX_SOC_LO: rd_data = chg_snap_reg[7:0];
			IDX_VOLT_HI: rd_data = volt_snap_reg[15:8];
			IDX_VOLT_LO: rd_data = volt_snap_reg[7:0];
			IDX_CHG_ALM: rd_data = chg_alm_reg;
			IDX_VOLT_ALM: rd_data = volt_alm_reg;
			default: rd_data = 8'h00;
		endcase
	end
endmodule

// ### core/bas_host_end.sv
`timescale 1ns/1ps
module bas_host_end
	import bas_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Link
	bas_link_if.host link
);
	localparam int QW = $clog2(I2C_QTR_CYC);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
	} bas_host_state_t;

	bas_host_state_t state_reg;
	logic [QW-1:0] qcnt_reg;
	logic [1:0] ph_reg;
	logic [3:0] bit_reg;
	logic [2:0] step_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic rx_mode_reg;
	logic ack_bit_reg;
	logic scl_reg;
	logic sda_low_reg;
	logic [2:0] sy_reg;
	logic sda_f_reg;
	logic cmd_read_reg;
	logic cmd_two_reg;
	logic [7:0] cmd_idx_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic [2:0] addr_sel_reg;
	logic nack_err_reg;
	logic rd_ack_reg;
	logic tick;
	logic go;
	logic last_rx;
	logic [2:0] step_n;

	assign tick = qcnt_reg == QW'(I2C_QTR_CYC - 1);
	assign go = write && address == HR_CMD && writedata[CMD_GO_BIT] && state_reg == H_IDLE;
	assign waitrequest = (write && address == HR_CMD && state_reg != H_IDLE) ||
		(read && !rd_ack_reg);
	assign last_rx = (step_reg == 3'h3 && !cmd_two_reg) || step_reg == 3'h4;
	assign step_n = step_reg + 3'h1;
	assign link.scl = scl_reg;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = sda_low_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sy_reg <= 3'h7;
			sda_f_reg <= 1'b1;
		end else begin
			sy_reg <= {sy_reg[1:0], link.sda};
			if (sy_reg[1] == sy_reg[2]) begin
				sda_f_reg <= sy_reg[2];
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wdata_reg <= 16'h0000;
			addr_sel_reg <= 3'h0;
			cmd_read_reg <= 1'b0;
			cmd_two_reg <= 1'b0;
			cmd_idx_reg <= 8'h00;
			rd_ack_reg <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			rd_ack_reg <= read && !rd_ack_reg;
			if (write && address == HR_WDATA) begin
				wdata_reg <= writedata[15:0];
			end
			if (write && address == HR_ADDR_SEL) begin
				addr_sel_reg <= writedata[2:0];
			end
			if (go) begin
				cmd_read_reg <= writedata[CMD_READ_BIT];
				cmd_two_reg <= writedata[CMD_TWO_BIT];
				cmd_idx_reg <= writedata[15:8];
			end
			if (read && !rd_ack_reg) begin
				unique case (address)
					HR_CMD: readdata <= {16'h0000, cmd_idx_reg, 5'h00, cmd_two_reg,
						cmd_read_reg, 1'b0};
					HR_WDATA: readdata <= {16'h0000, wdata_reg};
					HR_STATUS: readdata <= {30'h0000_0000, nack_err_reg, state_reg != H_IDLE};
					HR_RDATA: readdata <= {16'h0000, rdata_reg};
					HR_ADDR_SEL: readdata <= {29'h0000_0000, addr_sel_reg};
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= H_IDLE;
			qcnt_reg <= '0;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			step_reg <= 3'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			rx_mode_reg <= 1'b0;
			ack_bit_reg <= 1'b0;
			scl_reg <= 1'b1;
			sda_low_reg <= 1'b0;
			nack_err_reg <= 1'b0;
			rdata_reg <= 16'h0000;
		end else if (state_reg == H_IDLE) begin
			qcnt_reg <= '0;
			ph_reg <= 2'h0;
			if (go) begin
				step_reg <= 3'h0;
				nack_err_reg <= 1'b0;
				state_reg <= H_START;
			end
		end else begin
			qcnt_reg <= tick ? '0 : qcnt_reg + QW'(1);
			if (tick) begin
				ph_reg <= ph_reg + 2'h1;
				unique case (state_reg)
					H_START: begin
						// Also used as repeated start before the read address
						if (ph_reg == 2'h0) begin
							scl_reg <= 1'b0;
							sda_low_reg <= 1'b0;
						end else if (ph_reg == 2'h1) begin
							scl_reg <= 1'b1;
						end else if (ph_reg == 2'h2) begin
							sda_low_reg <= 1'b1;
						end else begin
							scl_reg <= 1'b0;
							tx_reg <= {DEV_ADDR_HI, addr_sel_reg, step_reg != 3'h0};
							rx_mode_reg <= 1'b0;
							bit_reg <= 4'h0;
							state_reg <= H_BIT;
						end
					end
					H_BIT: begin
						if (ph_reg == 2'h0) begin
							scl_reg <= 1'b0;
							if (bit_reg != 4'h8) begin
								sda_low_reg <= !rx_mode_reg && !tx_reg[7];
							end else begin
								sda_low_reg <= rx_mode_reg && !last_rx;
							end
						end else if (ph_reg == 2'h1) begin
							scl_reg <= 1'b1;
						end else if (ph_reg == 2'h2) begin
							if (bit_reg != 4'h8) begin
								rx_reg <= {rx_reg[6:0], sda_f_reg};
								tx_reg <= {tx_reg[6:0], 1'b0};
							end else begin
								ack_bit_reg <= sda_f_reg;
							end
						end else if (bit_reg != 4'h8) begin
							scl_reg <= 1'b0;
							bit_reg <= bit_reg + 4'h1;
						end else begin
							scl_reg <= 1'b0;
							sda_low_reg <= 1'b0;
							bit_reg <= 4'h0;
							step_reg <= step_n;
							if (rx_mode_reg) begin
								rdata_reg <= {rdata_reg[7:0], rx_reg};
							end
							rx_mode_reg <= 1'b0;
							if (!rx_mode_reg && ack_bit_reg) begin
								nack_err_reg <= 1'b1;
								state_reg <= H_STOP;
							end else if (step_n == 3'h1) begin
								tx_reg <= cmd_idx_reg;
							end else if (!cmd_read_reg && step_n == 3'h2) begin
								tx_reg <= cmd_two_reg ? wdata_reg[15:8] : wdata_reg[7:0];
							end else if (!cmd_read_reg && step_n == 3'h3 && cmd_two_reg) begin
								tx_reg <= wdata_reg[7:0];
							end else if (cmd_read_reg && step_n == 3'h2) begin
								state_reg <= H_START;
							end else if (cmd_read_reg && (step_n == 3'h3 ||
								(step_n == 3'h4 && cmd_two_reg))) begin
								rx_mode_reg <= 1'b1;
							end else begin
								state_reg <= H_STOP;
							end
						end
					end
					H_STOP: begin
						if (ph_reg == 2'h0) begin
							scl_reg <= 1'b0;
							sda_low_reg <= 1'b1;
						end else if (ph_reg == 2'h1) begin
							scl_reg <= 1'b1;
						end else if (ph_reg == 2'h2) begin
							sda_low_reg <= 1'b0;
						end else begin
							state_reg <= H_IDLE;
						end
					end
					default: state_reg <= H_IDLE;
				endcase
			end
		end
	end
endmodule

// ### verif/bas_link_chk.sv
`timescale 1ns/1ps
module bas_link_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_dev_pulls_low: assert property (sda_dev_o == 1'b0) else $error("dev high");
	a_host_pulls_low: assert property (sda_host_o == 1'b0) else $error("host high");
	a_dev_moves_low: assert property ($changed(sda_dev_oe) |-> !scl) else $error("dev edge");
	a_start_by_host: assert property (scl && $rose(sda_host_oe) |-> !sda_dev_oe)
		else $error("dev at start");
	a_ack_stands: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8]) else $error("ack short");
	a_scl_high_len: assert property ($rose(scl) |-> scl [*8]) else $error("scl high short");
	a_scl_low_len: assert property ($fell(scl) |-> !scl [*8]) else $error("scl low short");
	a_scl_low_end: assert property ($fell(scl) |-> ##[1:400] scl) else $error("scl stuck");
endmodule

// ### verif/battery_alarm_startup_supervisor_tb.sv
`timescale 1ns/1ps
module battery_alarm_startup_supervisor_tb;
	import bas_pkg::*;
	logic clock = 0, arst_n = 0, read = 0, write = 0, vv = 0, cv = 0, lock = 0, ext_n = 0;
	logic bat_hi = 0;
	logic [2:0] sel = 3'h5;
	logic [4:0] address = '0;
	logic [31:0] writedata = '0, readdata, q;
	logic [15:0] volt = '0, chg = '0;
	logic waitrequest, meas_start, al_o, al_oe, bd_o, bd_oe, rs_o, rs_oe;
	int miscompares = 0, check_count = 0;
	bas_link_if link ();
	always #5 clock = !clock;
	bas_host_end i_bas_host_end (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.link(link));
	bas_device_end #(.SWAP_FILTER_CYCLES(200), .DEBOUNCE_CYCLES(50)) i_bas_device_end (
		.clock(clock), .arst_n(arst_n), .link(link), .address_select(sel),
		.meas_start(meas_start), .voltage_value(volt), .voltage_valid(vv), .charge_value(chg),
		.charge_valid(cv), .alarm_out_i(!(al_oe && !al_o)), .alarm_out_o(al_o),
		.alarm_out_oe(al_oe), .battery_detect_pin_i(bat_hi || (bd_oe && bd_o)),
		.battery_detect_pin_o(bd_o),
		.battery_detect_pin_oe(bd_oe), .system_reset_pin_i(ext_n && !(rs_oe && !rs_o)),
		.system_reset_pin_o(rs_o), .system_reset_pin_oe(rs_oe), .supply_lockout(lock));
	bas_link_chk i_bas_link_chk (.clock(clock), .arst_n(arst_n), .scl(link.scl), .sda(link.sda),
		.sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
		.sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task give_up;
		miscompares++;
		close_out();
	endtask
	task av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20000);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clock);
		if (n >= 20000) give_up();
	endtask
	// Byte-wide or two-byte register access across the link, polled to completion
	task i2c(input logic rd, input logic two, input logic [7:0] idx, input logic [15:0] d);
		int n;
		av(1, HR_WDATA, {16'h0, d});
		av(1, HR_CMD, {16'h0, idx, 5'h0, two, rd, 1'b1});
		n = 0;
		do begin
			av(0, HR_STATUS, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 5000);
		if (n >= 5000) give_up();
		chk(q[1:0], 0);
		if (rd) av(0, HR_RDATA, 0);
	endtask
	task wait_on;
		int n;
		for (n = 0; n < 400 && meas_start !== 1'b1; n++) @(posedge clock);
		if (n == 400) give_up();
	endtask
	task feed(input logic [15:0] v, input logic [15:0] c);
		volt <= v;
		chg <= c;
		vv <= 1'b1;
		cv <= 1'b1;
		@(posedge clock);
		vv <= 1'b0;
		cv <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	initial begin
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		wait_on();
		@(posedge clock);
		ext_n <= 1'b1;
		chk({bd_oe, bd_o, rs_oe, al_oe}, 4'hE);
		feed(16'h0100, 16'h4000);
		chk({bd_oe, rs_oe, al_oe}, 3'h1);
		// Non-zero select bits on both ends, so a device that ignores them is refused
		av(1, HR_ADDR_SEL, {29'h0, sel});
		i2c(1, 1, IDX_CHG_ALM, 0);
		chk(q[15:8], CHG_ALM_RST);
		chk(q[7:0], VOLT_ALM_RST);
		i2c(1, 1, IDX_VOLT_HI, 0);
		chk(q[15:0], 16'h0100);
		i2c(1, 1, IDX_MODE, 0);
		chk(q[8 + MODE_ALM_EN_BIT], 1);
		chk(q[7:0] & 8'h61, 8'h40);
		i2c(0, 0, IDX_CTRL, 8'h01);
		chk(al_oe, 0);
		feed(16'h0100, 16'h4000);
		chk(al_oe, 0);
		feed(16'h0100, 16'h0100);
		chk(al_oe, 1);
		i2c(1, 0, IDX_CTRL, 0);
		chk(q[7:0] & 8'h61, 8'h20);
		i2c(0, 0, IDX_CTRL, 8'h00);
		feed(16'h4000, 16'h4000);
		chk(al_oe, 1);
		i2c(0, 0, IDX_CTRL, 8'h01);
		chk(al_oe, 0);
		i2c(0, 1, IDX_CHG_ALM, 16'h1080);
		lock <= 1'b1;
		repeat (150) @(posedge clock);
		lock <= 1'b0;
		i2c(1, 1, IDX_CHG_ALM, 0);
		chk(q[15:0], 16'h1080);
		lock <= 1'b1;
		repeat (230) @(posedge clock);
		lock <= 1'b0;
		wait_on();
		feed(16'h4000, 16'h4000);
		i2c(1, 1, IDX_CHG_ALM, 0);
		chk(q[15:0], {CHG_ALM_RST, VOLT_ALM_RST});
		bat_hi <= 1'b1;
		repeat (230) @(posedge clock);
		bat_hi <= 1'b0;
		wait_on();
		chk(bd_oe, 1);
		feed(16'h4000, 16'h4000);
		close_out();
	end
endmodule
